// >>> rtl/ddsl_pkg.sv
// constants shared by the dual converter serial load logic
package ddsl_pkg;
  localparam int          WORD_W      = 16;
  localparam int          CODE_W      = 14;
  localparam int          ADDR_HI_POS = 15;
  localparam int          ADDR_LO_POS = 14;
  localparam logic [13:0] ZERO_CODE   = 14'h0000;
  localparam logic [13:0] HALF_CODE   = 14'h2000;
  localparam logic [1:0]  ADDR_NONE   = 2'h0;
  localparam logic [1:0]  ADDR_A      = 2'h1;
  localparam logic [1:0]  ADDR_B      = 2'h2;
  localparam logic [1:0]  ADDR_BOTH   = 2'h3;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          PIN_COUNT   = 7;
  localparam logic [1:0]  POR_CYCLES  = 2'h3;
endpackage

// >>> rtl/ddsl_fifo_if.sv
// word path between the serial front end and the word store
`timescale 1ns/100ps
`default_nettype none
interface ddsl_fifo_if #(
  parameter int W = 16
);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic         flush;

  modport fill  (output push_valid, output push_data, output flush, input push_ready);
  modport store (input push_valid, input push_data, input flush, input pop_ready,
                 output push_ready, output pop_valid, output pop_data);
  modport drain (input pop_valid, input pop_data, output pop_ready);
endinterface
`default_nettype wire

// >>> rtl/ddsl_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none
module ddsl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] stab_ff;

  always_ff @(posedge clk) begin
    meta_ff <= din;
    stab_ff <= meta_ff;
  end

  assign dout = stab_ff;
endmodule
`default_nettype wire

// >>> rtl/ddsl_fifo.sv
// word store with valid/ready on both sides and a flush
`timescale 1ns/100ps
`default_nettype none
module ddsl_fifo #(
  parameter int W = ddsl_pkg::WORD_W,
  parameter int D = ddsl_pkg::FIFO_DEPTH
) (
  input  wire logic clk,
  input  wire logic rst_n,
  ddsl_fifo_if.store bus
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);

  logic [W-1:0]  mem_ff [D];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;
  logic          do_push;
  logic          do_pop;

  assign bus.push_ready = (cnt_ff != FULL_CNT);
  assign bus.pop_valid  = (cnt_ff != '0);
  assign bus.pop_data   = mem_ff[rd_ptr_ff];
  assign do_push = bus.push_valid && bus.push_ready && !bus.flush;
  assign do_pop  = bus.pop_valid && bus.pop_ready && !bus.flush;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(D - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= bus.push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || bus.flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (do_pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ddsl_top.sv
// serial load, input and converter registers of a dual 14-bit converter
//
// Functional notes
// - every transfer moves one 16-bit word into the serial shift register.
// - the word arrives top bit first and the first bit received ends in bit 15.
// - data is sampled on each rising link clock edge, shifting one bit per edge.
// - bits are accepted only while chip select is low; otherwise the shifter holds.
// - when more than sixteen bits arrive only the last sixteen are used.
// - a rising chip select queues the word; its code bits reach the addressed input registers while update_hold is low.
// - bit 15 is the upper address bit, bit 14 the lower, bits 13..0 the code.
// - address 00 loads nothing, 01 channel A, 10 channel B, 11 both alike.
// - converter registers follow input registers while the strobe is low, else hold.
// - the one load strobe moves both channels in the same cycle.
// - while preset is low the input and converter registers are forced to 0000h or 2000h by the level pin; the shifter still shifts but no word is queued.
// - two independent 14-bit channels each have an input and a converter register.
// - the load strobe is a level-sensitive active-low input untouched by chip select.
// - after reset all registers take zero or half scale until a serial load occurs.
`timescale 1ns/100ps
`default_nettype none
module ddsl_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        chip_sel_n,
  input  wire logic        serial_data_in,
  input  wire logic        load_strobe_n,
  input  wire logic        preset_n,
  input  wire logic        half_scale_sel,
  input  wire logic        update_hold,
  output var  logic [13:0] dac_code_a,
  output var  logic [13:0] dac_code_b,
  output var  logic [13:0] input_code_a,
  output var  logic [13:0] input_code_b,
  output var  logic        word_dropped,
  output var  logic        store_full
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finders
  logic [ddsl_pkg::PIN_COUNT-1:0] pin_s;
  logic                           sclk_s;
  logic                           cs_n_s;
  logic                           sdi_s;
  logic                           load_strobe_n_n_s;
  logic                           preset_n_s;
  logic                           half_s;
  logic                           hold_s;
  logic                           sclk_d_ff;
  logic                           cs_d_ff;
  logic                           sclk_rise;
  logic                           cs_rise;

  ddsl_sync #(
    .W(ddsl_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk  (clk),
    .din  ({link_clk, chip_sel_n, serial_data_in, load_strobe_n,
            preset_n, half_scale_sel, update_hold}),
    .dout (pin_s)
  );

  assign {sclk_s, cs_n_s, sdi_s, load_strobe_n_n_s, preset_n_s, half_s, hold_s} = pin_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_ff;
  assign cs_rise   = cs_n_s && !cs_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // power-on settling and preset
  logic [1:0]                   por_cnt_ff;
  logic                         preset_act;
  logic [ddsl_pkg::CODE_W-1:0]  preset_code;

  // hold preset until the level pin has passed its synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_cnt_ff <= ddsl_pkg::POR_CYCLES;
    end else if (por_cnt_ff != 2'h0) begin
      por_cnt_ff <= por_cnt_ff - 2'h1;
    end
  end

  assign preset_act  = (por_cnt_ff != 2'h0) || !preset_n_s;
  assign preset_code = half_s ? ddsl_pkg::HALF_CODE : ddsl_pkg::ZERO_CODE;

  ////////////////////////////////////////////////////////////////////////////
  // serial shift register
  logic [ddsl_pkg::WORD_W-1:0] shift_ff;

  // older bits fall off the top, so the last sixteen remain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_ff <= '0;
    end else if (sclk_rise && !cs_n_s) begin
      shift_ff <= {shift_ff[ddsl_pkg::WORD_W-2:0], sdi_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word store between the link and the input registers
  ddsl_fifo_if #(.W(ddsl_pkg::WORD_W)) fif ();

  assign fif.push_valid = cs_rise && !preset_act;
  assign fif.push_data  = shift_ff;
  assign fif.flush      = preset_act;
  assign fif.pop_ready  = !hold_s && !preset_act;

  ddsl_fifo #(
    .W(ddsl_pkg::WORD_W),
    .D(ddsl_pkg::FIFO_DEPTH)
  ) u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (fif)
  );

  logic word_dropped_ff;
  logic store_full_ff;

  // a word arriving at a full store is lost and flagged for one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_dropped_ff <= 1'b0;
      store_full_ff   <= 1'b0;
    end else begin
      word_dropped_ff <= fif.push_valid && !fif.push_ready;
      store_full_ff   <= !fif.push_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input registers
  logic                        pop;
  logic [1:0]                  pop_addr;
  logic [ddsl_pkg::CODE_W-1:0] pop_code;
  logic [1:0]                  chan_sel;
  logic [ddsl_pkg::CODE_W-1:0] input_a_ff;
  logic [ddsl_pkg::CODE_W-1:0] input_b_ff;

  // bit 0 of the result selects channel A, bit 1 channel B
  function automatic logic [1:0] chan_decode(input logic [1:0] addr);
    case (addr)
      ddsl_pkg::ADDR_NONE: chan_decode = 2'h0;
      ddsl_pkg::ADDR_A:    chan_decode = 2'h1;
      ddsl_pkg::ADDR_B:    chan_decode = 2'h2;
      ddsl_pkg::ADDR_BOTH: chan_decode = 2'h3;
      default:             chan_decode = 2'h0;
    endcase
  endfunction

  assign pop      = fif.pop_valid && fif.pop_ready;
  assign pop_addr = {fif.pop_data[ddsl_pkg::ADDR_HI_POS],
                     fif.pop_data[ddsl_pkg::ADDR_LO_POS]};
  assign pop_code = fif.pop_data[ddsl_pkg::CODE_W-1:0];
  assign chan_sel = chan_decode(pop_addr);

  always_ff @(posedge clk) begin
    if (!rst_n || preset_act) begin
      input_a_ff <= preset_code;
    end else if (pop && chan_sel[0]) begin
      input_a_ff <= pop_code;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || preset_act) begin
      input_b_ff <= preset_code;
    end else if (pop && chan_sel[1]) begin
      input_b_ff <= pop_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter registers
  logic [ddsl_pkg::CODE_W-1:0] dac_a_ff;
  logic [ddsl_pkg::CODE_W-1:0] dac_b_ff;

  // one strobe, both channels; chip select plays no part here
  always_ff @(posedge clk) begin
    if (!rst_n || preset_act) begin
      dac_a_ff <= preset_code;
      dac_b_ff <= preset_code;
    end else if (!load_strobe_n_n_s) begin
      dac_a_ff <= input_a_ff;
      dac_b_ff <= input_b_ff;
    end
  end

  assign dac_code_a   = dac_a_ff;
  assign dac_code_b   = dac_b_ff;
  assign input_code_a = input_a_ff;
  assign input_code_b = input_b_ff;
  assign word_dropped = word_dropped_ff;
  assign store_full   = store_full_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_shift_advance: assert property (
    sclk_rise && !cs_n_s |=> shift_ff == {$past(shift_ff[14:0]), $past(sdi_s)}
  ) else $error("shift register did not take the sampled bit");

  a_shift_frozen: assert property (
    cs_n_s |=> $stable(shift_ff)
  ) else $error("shift register moved while chip select was high");

  a_load_chan_a: assert property (
    (cs_rise && !preset_act && !fif.pop_valid && shift_ff[15:14] == 2'h1)
      ##1 (!hold_s && !preset_act)
      |=> input_a_ff == $past(shift_ff[13:0], 2)
  ) else $error("channel A input register missed the loaded code");

  a_addr_none: assert property (
    pop && pop_addr == 2'h0 && !preset_act |=> $stable(input_a_ff) && $stable(input_b_ff)
  ) else $error("address none changed an input register");

  a_both_chan: assert property (
    pop && pop_addr == 2'h3 |=> input_a_ff == input_b_ff
  ) else $error("address both gave the channels different codes");

  a_dac_follow: assert property (
    !preset_act && !load_strobe_n_n_s |=> dac_a_ff == $past(input_a_ff) && dac_b_ff == $past(input_b_ff)
  ) else $error("converter registers not transparent under a low strobe");

  a_dac_hold: assert property (
    !preset_act && load_strobe_n_n_s |=> $stable(dac_a_ff) && $stable(dac_b_ff)
  ) else $error("converter registers moved under a high strobe");

  a_preset_force: assert property (
    !preset_n_s |=> input_a_ff == $past(preset_code) && input_b_ff == $past(preset_code)
                    && dac_a_ff == $past(preset_code) && dac_b_ff == $past(preset_code)
  ) else $error("preset did not force every register");

  a_por_value: assert property (
    por_cnt_ff == 2'h1 |=> dac_a_ff == $past(preset_code) && input_b_ff == $past(preset_code)
  ) else $error("power-on value missing at the end of settling");

  a_load_chan_b: assert property (
    (cs_rise && !preset_act && !fif.pop_valid && shift_ff[15:14] == ddsl_pkg::ADDR_B)
      ##1 (!hold_s && !preset_act)
      |=> input_b_ff == $past(shift_ff[13:0], 2)
  ) else $error("channel B input register missed the loaded code");

  a_only_chan_a: assert property (
    pop && pop_addr == ddsl_pkg::ADDR_A && !preset_act |=> $stable(input_b_ff)
  ) else $error("a channel A word changed channel B");

  a_only_chan_b: assert property (
    pop && pop_addr == ddsl_pkg::ADDR_B && !preset_act |=> $stable(input_a_ff)
  ) else $error("a channel B word changed channel A");

  a_input_keep: assert property (
    !pop && !preset_act |=> $stable(input_a_ff) && $stable(input_b_ff)
  ) else $error("input register moved without a loaded word");

  a_drop_pulse: assert property (
    fif.push_valid && !fif.push_ready |=> word_dropped_ff
  ) else $error("word lost at a full store was not flagged");

  a_preset_flush: assert property (
    preset_act |=> !fif.pop_valid && !word_dropped_ff
  ) else $error("preset left words in the store");

  a_por_hold: assert property (
    por_cnt_ff != 2'h0 |=> dac_a_ff == $past(preset_code) && dac_b_ff == $past(preset_code)
  ) else $error("converter registers left the power-on value while settling");
endmodule
`default_nettype wire

// >>> testbench/ddsl_host_model.sv
// serial host model driving the three-wire link
`timescale 1ns/100ps
`default_nettype none
module ddsl_host_model (
  output var logic link_clk,
  output var logic chip_sel_n,
  output var logic serial_data_in
);
  initial begin
    link_clk       = 1'b0;
    chip_sel_n     = 1'b1;
    serial_data_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // n bits top first; dry clocks with select high
  task automatic frame(input logic [31:0] w, input int n, input bit split, input bit dry);
    #1;
    chip_sel_n = dry;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      #62.5;
      link_clk = 1'b1;
      #62.5;
      link_clk = 1'b0;
      if (split && i == 8) begin
        #250;
      end
    end
    #62.5;
    chip_sel_n     = 1'b1;
    serial_data_in = ~serial_data_in;
    #100;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_ddsl_top.sv
// self-checking bench for the dual converter serial load logic
`timescale 1ns/100ps
`default_nettype none
`define CHECK_EQ(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t ns: got %h expected %h", $time, g, e); end end
module test_ddsl_top;
  logic        clk, rst_n, load_strobe_n, preset_n, half_scale_sel, update_hold;
  logic        link_clk, chip_sel_n, serial_data_in, word_dropped, store_full;
  logic [13:0] dac_code_a, dac_code_b, input_code_a, input_code_b, code;
  logic [55:0] notes[$];
  logic [55:0] cur, last, obs, e;
  logic [15:0] sh;
  bit          strobe_low;
  int          mismatches, n_tests, drops;

  ddsl_host_model host_u (.link_clk(link_clk), .chip_sel_n(chip_sel_n),
    .serial_data_in(serial_data_in));
  ddsl_top dut_u (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .chip_sel_n(chip_sel_n),
    .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n), .preset_n(preset_n),
    .half_scale_sel(half_scale_sel), .update_hold(update_hold), .dac_code_a(dac_code_a),
    .dac_code_b(dac_code_b), .input_code_a(input_code_a), .input_code_b(input_code_b),
    .word_dropped(word_dropped), .store_full(store_full));
  ////////////////////////////////////////////////////////////
  task automatic note(input logic [13:0] ia, ib, da, db);
    if ({ia, ib, da, db} !== cur) begin
      cur = {ia, ib, da, db};
      notes.push_back(cur);
    end
  endtask
  task automatic wait_quiet();
    for (int i = 0; i < 300 && notes.size() != 0; i++) @(posedge clk);
    `CHECK_EQ(notes.size(), 0)
  endtask
  // shifter tracked as the device should see it
  task automatic send(input logic [31:0] w, input int n, input bit split, input bit live);
    logic [13:0] ia, ib;
    for (int i = n - 1; i >= 0; i--) sh = {sh[14:0], w[i]};
    ia = cur[55:42];
    ib = cur[41:28];
    if (sh[14]) ia = sh[13:0];
    if (sh[15]) ib = sh[13:0];
    if (live) begin
      note(ia, ib, cur[27:14], cur[13:0]);
      if (strobe_low) note(ia, ib, ia, ib);
    end
    host_u.frame(w, n, split, 1'b0);
    // held words only appear once the hold is lifted
    if (live && update_hold !== 1'b1) wait_quiet();
  endtask
  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    obs = {input_code_a, input_code_b, dac_code_a, dac_code_b};
    if (rst_n === 1'b1 && obs !== last) begin
      e = (notes.size() == 0) ? last : notes.pop_front();
      `CHECK_EQ(obs, e)
      last = obs;
    end
    if (word_dropped === 1'b1) drops++;
  end
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
  initial begin
    {rst_n, update_hold, load_strobe_n} = 3'h0;
    {preset_n, half_scale_sel} = 2'h3;
    {cur, last, sh} = '0;
    strobe_low = 1'b1;
    void'($urandom(29));
    repeat (3) @(posedge clk);
    note(ddsl_pkg::HALF_CODE, ddsl_pkg::HALF_CODE, ddsl_pkg::HALF_CODE,
      ddsl_pkg::HALF_CODE);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    wait_quiet();
    end_test("power up");
    for (int a = 0; a < 4; a++) begin
      code = 14'($urandom);
      send({16'h0, a[1:0], code}, 16, 1'b0, 1'b1);
    end
    send(32'h000F_C5A3, 20, 1'b0, 1'b1);
    send(32'h0000_007E, 8, 1'b0, 1'b1);
    host_u.frame(32'h0000_FFFF, 16, 1'b0, 1'b1);
    send(32'h0000_0055, 8, 1'b0, 1'b1);
    send(32'h0000_B1C2, 16, 1'b1, 1'b1);
    end_test("serial framing");
    @(posedge clk) load_strobe_n <= 1'b1;
    strobe_low = 1'b0;
    repeat (4) @(posedge clk);
    send(32'h0000_8ABC, 16, 1'b0, 1'b1);
    send(32'h0000_4123, 16, 1'b0, 1'b1);
    @(posedge clk) load_strobe_n <= 1'b0;
    strobe_low = 1'b1;
    note(cur[55:42], cur[41:28], cur[55:42], cur[41:28]);
    wait_quiet();
    end_test("strobe");
    @(posedge clk) {preset_n, half_scale_sel} <= 2'h0;
    note(14'h0000, 14'h0000, 14'h0000, 14'h0000);
    wait_quiet();
    send(32'h0000_F333, 16, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    @(posedge clk) preset_n <= 1'b1;
    repeat (4) @(posedge clk);
    end_test("preset");
    @(posedge clk) {update_hold, load_strobe_n} <= 2'h3;
    strobe_low = 1'b0;
    for (int i = 1; i < 10; i++) send({16'h0, 2'h1, 14'(i)}, 16, 1'b0, i < 9);
    `CHECK_EQ(store_full, 1'b1)
    `CHECK_EQ(drops, 1)
    @(posedge clk) update_hold <= 1'b0;
    wait_quiet();
    @(posedge clk) load_strobe_n <= 1'b0;
    strobe_low = 1'b1;
    note(cur[55:42], cur[41:28], cur[55:42], cur[41:28]);
    wait_quiet();
    `CHECK_EQ(store_full, 1'b0)
    end_test("word store");
    complete_run();
  end
endmodule
`default_nettype wire
